/* ecrm_defines.vh */
// Constants for the Ethernet core register map: address ranges, local
// offsets, individually placed registers, reset values and answer timing.
// Assumes word addresses of 12 bits and 32-bit data words.
`ifndef ECRM_DEFINES_VH
`define ECRM_DEFINES_VH

// ----------------------------------------------------------------------
// Category ranges, selected by address bits [11:8]
// ----------------------------------------------------------------------
`define ECRM_CAT_KR 4'h0
`define ECRM_CAT_PHY 4'h3
`define ECRM_CAT_TXMAC 4'h4
`define ECRM_CAT_RXMAC 4'h5
`define ECRM_CAT_TXPAUSE 4'h6
`define ECRM_CAT_RXPAUSE 4'h7
`define ECRM_CAT_TXSTAT 4'h8
`define ECRM_CAT_RXSTAT 4'h9
`define ECRM_CAT_TXPTP 4'ha
`define ECRM_CAT_RXPTP 4'hb

// ----------------------------------------------------------------------
// Common registers at the start of each range except the backplane range
// ----------------------------------------------------------------------
`define ECRM_LOC_REVID 8'h00
`define ECRM_LOC_SCRATCH 8'h01
`define ECRM_LOC_NAME0 8'h02
`define ECRM_LOC_NAME2 8'h04

// ----------------------------------------------------------------------
// Backplane sub-ranges and their remap, and the reserved range
// ----------------------------------------------------------------------
`define ECRM_KR_TOP_LO 12'h0b0
`define ECRM_KR_TOP_HI 12'h0bd
`define ECRM_KR_FEC_LO 12'h0b8
`define ECRM_KR_AN_LO 12'h0c0
`define ECRM_KR_AN_HI 12'h0cc
`define ECRM_KR_LT_LO 12'h0d0
`define ECRM_KR_LT_HI 12'h0eb
`define ECRM_KR_REMAP 12'h400
`define ECRM_RSVD_LO 12'h100
`define ECRM_RSVD_HI 12'h2ff

// ----------------------------------------------------------------------
// Forwarded groups
// ----------------------------------------------------------------------
`define ECRM_PHY_LO 12'h310
`define ECRM_PHY_HI 12'h344
`define ECRM_TXPAUSE_LO 12'h605
`define ECRM_TXPAUSE_HI 12'h60a
`define ECRM_RXPAUSE_LO 12'h700
`define ECRM_RXPAUSE_HI 12'h703
`define ECRM_TXCNT_LO 12'h800
`define ECRM_TXCNT_HI 12'h837
`define ECRM_TXCNT2_LO 12'h860
`define ECRM_TXCNT2_HI 12'h861
`define ECRM_RXCNT_LO 12'h900
`define ECRM_RXCNT_HI 12'h937
`define ECRM_RXCNT2_LO 12'h960
`define ECRM_RXCNT2_HI 12'h961
`define ECRM_TXPTP_LO 12'ha00
`define ECRM_TXPTP_HI 12'ha0c
`define ECRM_RXPTP_LO 12'hb00
`define ECRM_RXPTP_HI 12'hb06

// ----------------------------------------------------------------------
// Individually placed registers
// ----------------------------------------------------------------------
`define ECRM_FAULT_CFG 12'h405
`define ECRM_IPG_REM 12'h406
`define ECRM_TX_LIMIT 12'h407
`define ECRM_RX_LIMIT 12'h506
`define ECRM_CRC_FWD 12'h507
`define ECRM_FAULT_STAT 12'h508
`define ECRM_LEN_CHECK 12'h50a
`define ECRM_TX_OVS_CNT 12'h80c
`define ECRM_TX_CNT_CFG 12'h845
`define ECRM_TX_CNT_STAT 12'h846
`define ECRM_RX_OVS_CNT 12'h90c
`define ECRM_RX_CNT_CFG 12'h945
`define ECRM_RX_CNT_STAT 12'h946

// ----------------------------------------------------------------------
// Field positions, reset values, constants
// ----------------------------------------------------------------------
`define ECRM_CNT_CFG_CLEAR 0
`define ECRM_CNT_STAT_SAT 0
`define ECRM_RST_ZERO 32'h00000000
`define ECRM_RST_LIMIT 32'h00002580
`define ECRM_RSVD_VALUE 32'h00000000
`define ECRM_REVID_VALUE 32'h00a5c301
`define ECRM_NAME_BASE 32'h65746820
`define ECRM_TIMEOUT_CYCLES 64

`endif

/* ecrm_regmap.v */
// Register map decoder for a 40 Gb/s Ethernet core's control port.
// Assumes a single requester that waits for each read answer before
// issuing its next request; the core's sub-blocks sit behind the
// forwarding port and answer reads with a one-cycle valid pulse.
`timescale 1ns/10ps
`include "ecrm_defines.vh"

module ecrm_regmap #(
    parameter EN_KR = 1,
    parameter EN_FEC = 1,
    parameter EN_AN = 1,
    parameter EN_LT = 1,
    parameter EN_FAULT = 1,
    parameter EN_AVG_IPG = 1,
    parameter EN_FLOW = 1,
    parameter EN_TX_STATS = 1,
    parameter EN_RX_STATS = 1,
    parameter EN_PTP = 1,
    parameter [31:0] REVID = `ECRM_REVID_VALUE, // Arbitrary value
    parameter TIMEOUT_CYCLES = `ECRM_TIMEOUT_CYCLES
) (
    input wire clk_in,
    input wire rst_n_in,

    input wire [11:0] status_address_in,
    input wire status_read_in,
    input wire status_write_in,
    input wire [31:0] status_writedata_in,
    output reg [31:0] status_readdata_out,
    output reg status_readdata_valid_out,
    output reg status_busy_out,
    output reg status_read_timeout_out,

    output reg [11:0] sub_address_out,
    output reg sub_read_out,
    output reg sub_write_out,
    output reg [31:0] sub_writedata_out,
    input wire [31:0] sub_readdata_in,
    input wire sub_readdata_valid_in,

    input wire tx_frame_done_in,
    input wire [31:0] tx_frame_len_in,
    input wire rx_frame_done_in,
    input wire [31:0] rx_frame_len_in,
    input wire [31:0] fault_status_in,

    output reg [31:0] fault_signal_config_out,
    output reg [31:0] idle_column_removal_out,
    output reg [31:0] rx_crc_forward_config_out,
    output reg rx_length_check_enable_out
);

    // ------------------------------------------------------------------
    // Address classification
    // ------------------------------------------------------------------
    wire [3:0] cat = status_address_in[11:8];
    wire [7:0] loc = status_address_in[7:0];
    wire [11:0] a = status_address_in;

    reg range_on;
    reg common_hit;
    reg fwd_hit;
    reg [11:0] fwd_addr;

    always @* begin
        case (cat)
            `ECRM_CAT_PHY, `ECRM_CAT_TXMAC, `ECRM_CAT_RXMAC: range_on = 1'b1;
            `ECRM_CAT_TXPAUSE, `ECRM_CAT_RXPAUSE: range_on = (EN_FLOW != 0);
            `ECRM_CAT_TXSTAT: range_on = (EN_TX_STATS != 0);
            `ECRM_CAT_RXSTAT: range_on = (EN_RX_STATS != 0);
            `ECRM_CAT_TXPTP, `ECRM_CAT_RXPTP: range_on = (EN_PTP != 0);
            default: range_on = 1'b0;
        endcase
    end

    always @* begin
        common_hit = range_on && (loc <= `ECRM_LOC_NAME2);

        fwd_addr = a;
        fwd_hit = 1'b0;

        if (a >= `ECRM_KR_TOP_LO && a <= `ECRM_KR_TOP_HI) begin
            fwd_hit = (EN_KR != 0) &&
                      (a < `ECRM_KR_FEC_LO || EN_FEC != 0);
        end else if (a >= `ECRM_KR_AN_LO && a <= `ECRM_KR_AN_HI) begin
            fwd_hit = (EN_KR != 0) && (EN_AN != 0);
        end else if (a >= `ECRM_KR_LT_LO && a <= `ECRM_KR_LT_HI) begin
            fwd_hit = (EN_KR != 0) && (EN_LT != 0);
        end else if (a >= `ECRM_PHY_LO && a <= `ECRM_PHY_HI) begin
            fwd_hit = 1'b1;
        end else if ((a >= `ECRM_TXPAUSE_LO && a <= `ECRM_TXPAUSE_HI) ||
                     (a >= `ECRM_RXPAUSE_LO && a <= `ECRM_RXPAUSE_HI)) begin
            fwd_hit = (EN_FLOW != 0);
        end else if (a != `ECRM_TX_OVS_CNT &&
                     ((a >= `ECRM_TXCNT_LO && a <= `ECRM_TXCNT_HI) ||
                      (a >= `ECRM_TXCNT2_LO && a <= `ECRM_TXCNT2_HI))) begin
            fwd_hit = (EN_TX_STATS != 0);
        end else if (a != `ECRM_RX_OVS_CNT &&
                     ((a >= `ECRM_RXCNT_LO && a <= `ECRM_RXCNT_HI) ||
                      (a >= `ECRM_RXCNT2_LO && a <= `ECRM_RXCNT2_HI))) begin
            fwd_hit = (EN_RX_STATS != 0);
        end else if ((a >= `ECRM_TXPTP_LO && a <= `ECRM_TXPTP_HI) ||
                     (a >= `ECRM_RXPTP_LO && a <= `ECRM_RXPTP_HI)) begin
            fwd_hit = (EN_PTP != 0);
        end

        if (cat == `ECRM_CAT_KR) begin
            fwd_addr = a + `ECRM_KR_REMAP;
        end

        if (common_hit) begin
            fwd_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Local registers
    // ------------------------------------------------------------------
    reg [31:0] scratch [0:15];

    reg [31:0] tx_frame_length_limit;
    reg [31:0] rx_frame_length_limit;
    reg [31:0] tx_counter_config;
    reg [31:0] rx_counter_config;

    reg [31:0] tx_oversize_counter;
    reg [31:0] rx_oversize_counter;

    reg local_hit;
    reg [31:0] local_data;

    wire accept = !status_busy_out;
    wire do_write = accept && status_write_in && !status_read_in;

    wire tx_sat = (tx_oversize_counter == 32'hffffffff);
    wire rx_sat = (rx_oversize_counter == 32'hffffffff);

    always @* begin
        local_hit = 1'b1;
        local_data = `ECRM_RSVD_VALUE;

        if (common_hit) begin
            case (loc)
                `ECRM_LOC_REVID: local_data = REVID;
                `ECRM_LOC_SCRATCH: local_data = scratch[cat];
                default: local_data = `ECRM_NAME_BASE + {24'h000000, cat, loc[3:0]};
            endcase
        end else begin
            case (a)
                `ECRM_FAULT_CFG: begin
                    local_hit = (EN_FAULT != 0);
                    local_data = fault_signal_config_out;
                end

                `ECRM_IPG_REM: begin
                    local_hit = (EN_AVG_IPG != 0);
                    local_data = idle_column_removal_out;
                end

                `ECRM_TX_LIMIT: local_data = tx_frame_length_limit;
                `ECRM_RX_LIMIT: local_data = rx_frame_length_limit;
                `ECRM_CRC_FWD: local_data = rx_crc_forward_config_out;

                `ECRM_FAULT_STAT: begin
                    local_data = (EN_FAULT != 0) ? fault_status_in :
                                 `ECRM_RST_ZERO;
                end

                `ECRM_LEN_CHECK: local_data = {31'h00000000, rx_length_check_enable_out};

                `ECRM_TX_OVS_CNT, `ECRM_TX_CNT_CFG, `ECRM_TX_CNT_STAT: begin
                    local_hit = (EN_TX_STATS != 0);
                    if (a == `ECRM_TX_OVS_CNT) begin
                        local_data = tx_oversize_counter;
                    end else if (a == `ECRM_TX_CNT_CFG) begin
                        local_data = tx_counter_config;
                    end else begin
                        local_data = {31'h00000000, tx_sat};
                    end
                end

                `ECRM_RX_OVS_CNT, `ECRM_RX_CNT_CFG, `ECRM_RX_CNT_STAT: begin
                    local_hit = (EN_RX_STATS != 0);
                    if (a == `ECRM_RX_OVS_CNT) begin
                        local_data = rx_oversize_counter;
                    end else if (a == `ECRM_RX_CNT_CFG) begin
                        local_data = rx_counter_config;
                    end else begin
                        local_data = {31'h00000000, rx_sat};
                    end
                end

                default: local_hit = 1'b0;
            endcase
        end

        if (!local_hit) begin
            local_data = `ECRM_RSVD_VALUE;
        end
    end

    // Scratch word per range; reserved and read-only words take no write
    genvar gi;

    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_scratch
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    scratch[gi] <= `ECRM_RST_ZERO;
                end else if (do_write && common_hit && cat == gi &&
                             loc == `ECRM_LOC_SCRATCH) begin
                    scratch[gi] <= status_writedata_in;
                end
            end
        end
    endgenerate

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_signal_config_out <= `ECRM_RST_ZERO;
            idle_column_removal_out <= `ECRM_RST_ZERO;
            tx_frame_length_limit <= `ECRM_RST_LIMIT;
            rx_frame_length_limit <= `ECRM_RST_LIMIT;
            rx_crc_forward_config_out <= `ECRM_RST_ZERO;
            rx_length_check_enable_out <= 1'b0;
            tx_counter_config <= `ECRM_RST_ZERO;
            rx_counter_config <= `ECRM_RST_ZERO;
        end else if (do_write && !common_hit && local_hit) begin
            // Read-only and reserved words fall through untouched
            case (a)
                `ECRM_FAULT_CFG: fault_signal_config_out <= status_writedata_in;
                `ECRM_IPG_REM: idle_column_removal_out <= status_writedata_in;
                `ECRM_TX_LIMIT: tx_frame_length_limit <= status_writedata_in;
                `ECRM_RX_LIMIT: rx_frame_length_limit <= status_writedata_in;
                `ECRM_CRC_FWD: rx_crc_forward_config_out <= status_writedata_in;
                `ECRM_LEN_CHECK: begin
                    rx_length_check_enable_out <= status_writedata_in[0];
                end
                `ECRM_TX_CNT_CFG: tx_counter_config <= status_writedata_in;
                `ECRM_RX_CNT_CFG: rx_counter_config <= status_writedata_in;

                default: tx_counter_config <= tx_counter_config;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Oversize counters
    // ------------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_oversize_counter <= `ECRM_RST_ZERO;
            rx_oversize_counter <= `ECRM_RST_ZERO;
        end else begin
            if (tx_counter_config[`ECRM_CNT_CFG_CLEAR]) begin
                tx_oversize_counter <= `ECRM_RST_ZERO;
            end else if (tx_frame_done_in && tx_frame_len_in > tx_frame_length_limit &&
                         !tx_sat) begin
                tx_oversize_counter <= tx_oversize_counter + 32'h00000001;
            end

            if (rx_counter_config[`ECRM_CNT_CFG_CLEAR]) begin
                rx_oversize_counter <= `ECRM_RST_ZERO;
            end else if (rx_frame_done_in && rx_frame_len_in > rx_frame_length_limit &&
                         !rx_sat) begin
                rx_oversize_counter <= rx_oversize_counter + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request handling and forwarding
    // ------------------------------------------------------------------
    reg [7:0] wait_count;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_readdata_out <= `ECRM_RST_ZERO;
            status_readdata_valid_out <= 1'b0;
            status_busy_out <= 1'b0;
            status_read_timeout_out <= 1'b0;
            sub_address_out <= 12'h000;
            sub_read_out <= 1'b0;
            sub_write_out <= 1'b0;
            sub_writedata_out <= `ECRM_RST_ZERO;
            wait_count <= 8'h00;
        end else begin
            status_readdata_valid_out <= 1'b0;
            status_read_timeout_out <= 1'b0;
            sub_read_out <= 1'b0;
            sub_write_out <= 1'b0;

            if (status_busy_out) begin
                wait_count <= wait_count + 8'h01;

                if (sub_readdata_valid_in) begin
                    status_readdata_out <= sub_readdata_in;
                    status_readdata_valid_out <= 1'b1;
                    status_busy_out <= 1'b0;
                end else if (wait_count == TIMEOUT_CYCLES - 1) begin
                    status_readdata_out <= `ECRM_RSVD_VALUE;
                    status_readdata_valid_out <= 1'b1;
                    status_read_timeout_out <= 1'b1;
                    status_busy_out <= 1'b0;
                end
            end else if (status_read_in && fwd_hit) begin
                sub_address_out <= fwd_addr;
                sub_read_out <= 1'b1;
                status_busy_out <= 1'b1;
                wait_count <= 8'h00;
            end else if (status_read_in) begin
                status_readdata_out <= local_data;
                status_readdata_valid_out <= 1'b1;
            end else if (status_write_in && fwd_hit) begin
                sub_address_out <= fwd_addr;
                sub_writedata_out <= status_writedata_in;
                sub_write_out <= 1'b1;
            end
        end
    end

endmodule

/* ecrm_regmap_monitor.sv */
// Checker for the register map decoder: answer timing, decode and remap.
// Assumes it is bound to every decoder instance, with options as parameters.
`timescale 1ns/10ps
`include "ecrm_defines.vh"

module ecrm_regmap_monitor #(
    parameter EN_KR = 1,
    parameter EN_FAULT = 1,
    parameter TIMEOUT_CYCLES = 64
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [11:0] status_address_in,
    input wire status_read_in,
    input wire status_write_in,
    input wire [31:0] status_readdata_out,
    input wire status_readdata_valid_out,
    input wire status_busy_out,
    input wire status_read_timeout_out,
    input wire [11:0] sub_address_out,
    input wire sub_read_out,
    input wire sub_write_out,
    input wire [31:0] sub_readdata_in,
    input wire sub_readdata_valid_in,
    input wire [31:0] fault_status_in
);
    wire [11:0] a = status_address_in;
    wire rd_take = status_read_in && !status_busy_out;
    wire any_take = (status_read_in || status_write_in) && !status_busy_out;
    wire rsvd = a >= `ECRM_RSVD_LO && a <= `ECRM_RSVD_HI;
    wire sub_any = sub_read_out || sub_write_out;
    reg [15:0] busy_len;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Length of the current forwarded read
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            busy_len <= 16'h0000;
        else
            busy_len <= status_busy_out ? busy_len + 16'h0001 : 16'h0000;
    end

    a_read_answer: assert property (rd_take |=> status_readdata_valid_out || sub_read_out)
        else $error("read got no answer");
    a_rsvd_read: assert property (rd_take && rsvd |=> status_readdata_valid_out
        && status_readdata_out == `ECRM_RSVD_VALUE) else $error("reserved read value");
    a_rsvd_quiet: assert property (any_take && rsvd |=> !sub_any)
        else $error("reserved access forwarded");
    a_kr_remap: assert property (any_take && EN_KR != 0 && a >= 12'h0b0
        && a <= 12'h0b7 |=> sub_any && sub_address_out == $past(a) + `ECRM_KR_REMAP)
        else $error("kr remap");
    a_phy_forward: assert property (any_take && a >= `ECRM_PHY_LO && a <= `ECRM_PHY_HI
        |=> sub_any && sub_address_out == $past(a)) else $error("phy forward");
    a_fault_read: assert property (rd_take && a == `ECRM_FAULT_STAT |=>
        status_readdata_out == (EN_FAULT != 0 ? $past(fault_status_in) : 32'h0))
        else $error("fault status read");
    a_fwd_answer: assert property (status_busy_out && sub_readdata_valid_in |=>
        status_readdata_valid_out && !status_busy_out
        && status_readdata_out == $past(sub_readdata_in)) else $error("forwarded answer");
    a_busy_end: assert property ($fell(status_busy_out) |-> status_readdata_valid_out)
        else $error("busy ended without answer");
    a_busy_bound: assert property (busy_len <= TIMEOUT_CYCLES)
        else $error("forwarded read too long");
    a_timeout_pulse: assert property (status_read_timeout_out |->
        status_readdata_valid_out && $fell(status_busy_out)) else $error("timeout pulse");
    a_sub_busy: assert property (sub_read_out |-> status_busy_out)
        else $error("forwarded read not busy");
    a_write_silent: assert property (any_take && !status_read_in |=>
        !status_readdata_valid_out) else $error("write answered");
endmodule

bind ecrm_regmap ecrm_regmap_monitor #(.EN_KR(EN_KR), .EN_FAULT(EN_FAULT),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .status_address_in(status_address_in), .status_read_in(status_read_in),
    .status_write_in(status_write_in), .status_readdata_out(status_readdata_out),
    .status_readdata_valid_out(status_readdata_valid_out),
    .status_busy_out(status_busy_out), .status_read_timeout_out(status_read_timeout_out),
    .sub_address_out(sub_address_out), .sub_read_out(sub_read_out),
    .sub_write_out(sub_write_out), .sub_readdata_in(sub_readdata_in),
    .sub_readdata_valid_in(sub_readdata_valid_in), .fault_status_in(fault_status_in));

/* ecrm_regmap_tb.sv */
// Bench for the register map decoder: a full instance and a minimal one
// share the bus; the bench answers forwarded reads of the full instance.
`timescale 1ns/10ps
`include "ecrm_defines.vh"

module ecrm_regmap_tb;
    localparam TO = 8;
    localparam OFF = 0;
    localparam [119:0] FWD = {12'h605, 12'h60a, 12'h608, 12'h837, 12'h860,
        12'h961, 12'h905, 12'ha0c, 12'hb06, 12'h805};
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [11:0] addr = 12'h000;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg [31:0] sub_rdata = 32'h0;
    reg sub_valid = 1'b0;
    reg tx_done = 1'b0;
    reg rx_done = 1'b0;
    reg [31:0] flen = 32'h0;
    reg [31:0] fstat = 32'h0;
    reg sub_mute = 1'b0;
    reg [3:0] sub_lat = 4'h1;
    reg [3:0] sub_cnt = 4'h0;
    reg [11:0] sub_q = 12'h0;
    reg [31:0] rdat;
    reg rto;
    reg sw_seen;
    reg [11:0] sw_addr;
    reg [31:0] sw_data;
    integer err_total = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer k;
    wire [31:0] rdata_f, rdata_m, sub_wd, fcfg_f, fcfg_m, ipg_f, ipg_m, crc_f;
    wire valid_f, valid_m, busy_f, busy_m, to_f, sub_rd, sub_wr, len_f;
    wire [11:0] sub_addr;

    ecrm_regmap #(.TIMEOUT_CYCLES(TO)) i_ecrm_regmap (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .status_address_in(addr), .status_read_in(rd), .status_write_in(wr),
        .status_writedata_in(wdata), .status_readdata_out(rdata_f),
        .status_readdata_valid_out(valid_f), .status_busy_out(busy_f),
        .status_read_timeout_out(to_f), .sub_address_out(sub_addr), .sub_read_out(sub_rd),
        .sub_write_out(sub_wr), .sub_writedata_out(sub_wd), .sub_readdata_in(sub_rdata),
        .sub_readdata_valid_in(sub_valid), .tx_frame_done_in(tx_done), .tx_frame_len_in(flen),
        .rx_frame_done_in(rx_done), .rx_frame_len_in(flen), .fault_status_in(fstat),
        .fault_signal_config_out(fcfg_f), .idle_column_removal_out(ipg_f),
        .rx_crc_forward_config_out(crc_f), .rx_length_check_enable_out(len_f));
    ecrm_regmap #(.EN_KR(OFF), .EN_FEC(OFF), .EN_AN(OFF), .EN_LT(OFF), .EN_FAULT(OFF),
        .EN_AVG_IPG(OFF), .EN_FLOW(OFF), .EN_TX_STATS(OFF), .EN_RX_STATS(OFF),
        .EN_PTP(OFF), .TIMEOUT_CYCLES(TO))
        i_ecrm_regmap_min (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .status_address_in(addr), .status_read_in(rd), .status_write_in(wr),
        .status_writedata_in(wdata), .status_readdata_out(rdata_m),
        .status_readdata_valid_out(valid_m), .status_busy_out(busy_m),
        .status_read_timeout_out(), .sub_address_out(), .sub_read_out(),
        .sub_write_out(), .sub_writedata_out(), .sub_readdata_in(sub_rdata),
        .sub_readdata_valid_in(sub_valid), .tx_frame_done_in(tx_done), .tx_frame_len_in(flen),
        .rx_frame_done_in(rx_done), .rx_frame_len_in(flen), .fault_status_in(fstat),
        .fault_signal_config_out(fcfg_m), .idle_column_removal_out(ipg_m),
        .rx_crc_forward_config_out(), .rx_length_check_enable_out());

    always #4 clk_in = ~clk_in;

    // ------------------------------------------------------------------
    // Sub-block answer and run limit
    // ------------------------------------------------------------------
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        sub_valid <= 1'b0;
        if (sub_rd) begin
            sub_cnt <= sub_lat;
            sub_q <= sub_addr;
        end else if (sub_cnt != 4'h0) begin
            sub_cnt <= sub_cnt - 4'h1;
        end
        if (sub_cnt == 4'h1 && !sub_mute) begin
            sub_valid <= 1'b1;
            sub_rdata <= {20'h5a000, sub_q};
        end
        if (cyc == 20000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task chk(input string name, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %s exp %h seen %h", name, exp, seen);
            end
        end
    endtask

    task wrw(input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_in);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk_in);
            wr <= 1'b0;
            #1;
            sw_seen = sub_wr;
            sw_addr = sub_addr;
            sw_data = sub_wd;
        end
    endtask

    task rc(input s, input [11:0] a, input [31:0] e);
        integer n;
        begin
            @(posedge clk_in);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk_in);
            rd <= 1'b0;
            #1;
            for (n = 0; n < 40 && !(s ? valid_m : valid_f); n = n + 1)
                @(posedge clk_in) #1;
            rdat = (n < 40) ? (s ? rdata_m : rdata_f) : ~e;
            rto = to_f;
            chk($sformatf("read %0d %h", s, a), rdat, e);
            while (busy_f === 1'b1 || busy_m === 1'b1)
                @(posedge clk_in) #1;
        end
    endtask

    task ovs(input [11:0] lim, input [11:0] cnt, input [11:0] cfg, input tx);
        integer n;
        begin
            wrw(lim, 32'd100);
            rc(0, cnt, 32'h0);
            for (n = 100; n < 103; n = n + 1) begin
                @(posedge clk_in);
                flen <= n;
                tx_done <= tx;
                rx_done <= !tx;
                @(posedge clk_in);
                tx_done <= 1'b0;
                rx_done <= 1'b0;
            end
            rc(0, cnt, 32'h2);
            rc(1, cnt, 32'h0);
            wrw(cfg, 32'h1);
            rc(0, cnt, 32'h0);
            wrw(cfg, 32'h0);
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d errors %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rc(0, `ECRM_TX_LIMIT, `ECRM_RST_LIMIT);
        rc(0, `ECRM_RX_LIMIT, `ECRM_RST_LIMIT);
        for (k = 3; k < 12; k = k + 1) begin
            rc(0, {k[3:0], 8'h00}, `ECRM_REVID_VALUE);
            wrw({k[3:0], 8'h00}, 32'hffffffff);
            rc(0, {k[3:0], 8'h00}, `ECRM_REVID_VALUE);
            rc(0, {k[3:0], 8'h01}, 32'h0);
            wrw({k[3:0], 8'h01}, {k[7:0], 24'h3c5a96});
            rc(0, {k[3:0], 8'h01}, {k[7:0], 24'h3c5a96});
            rc(1, {k[3:0], 8'h01}, k < 6 ? {k[7:0], 24'h3c5a96} : 32'h0);
            rc(0, {k[3:0], 8'h04}, `ECRM_NAME_BASE + {k[3:0], 4'h4});
        end
        wrw(12'h100, 32'h12345678);
        chk("reserved fwd", {31'h0, sw_seen}, 32'h0);
        rc(0, 12'h100, `ECRM_RSVD_VALUE);
        rc(0, 12'h2ff, `ECRM_RSVD_VALUE);
        rc(0, 12'h0be, `ECRM_RSVD_VALUE);
        wrw(`ECRM_FAULT_CFG, 32'ha1b2c3d4);
        wrw(`ECRM_IPG_REM, 32'h00000005);
        wrw(`ECRM_CRC_FWD, 32'h00000001);
        wrw(`ECRM_LEN_CHECK, 32'h00000001);
        chk("fault cfg", fcfg_f, 32'ha1b2c3d4);
        chk("fault cfg min", fcfg_m, 32'h0);
        chk("idle rem", ipg_f, 32'h5);
        chk("idle rem min", ipg_m, 32'h0);
        chk("crc fwd", crc_f, 32'h1);
        chk("len check", {31'h0, len_f}, 32'h1);
        rc(1, `ECRM_FAULT_CFG, 32'h0);
        @(posedge clk_in);
        fstat <= 32'h00000003;
        wrw(`ECRM_FAULT_STAT, 32'h0);
        rc(0, `ECRM_FAULT_STAT, 32'h3);
        rc(1, `ECRM_FAULT_STAT, 32'h0);
        wrw(12'h310, 32'h0000002a);
        chk("phy write", {sw_seen, sw_addr, sw_data[18:0]}, {1'b1, 12'h310, 19'h2a});
        wrw(12'h0b3, 32'h1);
        chk("kr remap", {20'h0, sw_addr}, 32'h4b3);
        sub_lat <= 4'h5;
        rc(0, 12'h0c5, {20'h5a000, 12'h4c5});
        rc(1, 12'h0c5, `ECRM_RSVD_VALUE);
        rc(1, 12'h344, {20'h5a000, 12'h344});
        sub_lat <= 4'h1;
        for (k = 0; k < 10; k = k + 1) begin
            rc(0, FWD[k*12 +: 12], {20'h5a000, FWD[k*12 +: 12]});
            rc(1, FWD[k*12 +: 12], `ECRM_RSVD_VALUE);
        end
        sub_mute <= 1'b1;
        rc(1, 12'h320, 32'h0);
        chk("timeout", {31'h0, rto}, 32'h1);
        sub_mute <= 1'b0;
        ovs(`ECRM_TX_LIMIT, `ECRM_TX_OVS_CNT, `ECRM_TX_CNT_CFG, 1'b1);
        ovs(`ECRM_RX_LIMIT, `ECRM_RX_OVS_CNT, `ECRM_RX_CNT_CFG, 1'b0);
        stop_test;
    end
endmodule
